// file: cwg_consts.svh
`ifndef CWG_CONSTS_SVH
`define CWG_CONSTS_SVH

`define ADDR_CTRL 5'h00
`define ADDR_STEER 5'h04
`define ADDR_DEAD_RISE 5'h08
`define ADDR_DEAD_FALL 5'h0C
`define ADDR_BLANK_RISE 5'h10
`define ADDR_BLANK_FALL 5'h14
`define ADDR_PHASE 5'h18
`define ADDR_STATUS 5'h1C

`define MODE_HALF_BRIDGE 3'h4
`define MODE_PUSH_PULL 3'h5

`define CTRL_EN_BIT 0
`define CTRL_MODE_LSB 4
`define CTRL_CLR_BIT 8

`define STEER_A_BIT 0
`define STEER_B_BIT 1
`define STEER_C_BIT 2
`define STEER_D_BIT 3

`define CTRL_RESET 32'h00000000
`define STEER_RESET 4'hF
`define COUNT_RESET 8'h00

`endif

// file: cwg_pkg.sv
`default_nettype none
package cwg_pkg;
    typedef logic [7:0] count_t;
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } drive_t;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_PHASE,
        ST_ON
    } drive_state_t;
endpackage
`default_nettype wire

// file: complementary_waveform_generator.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`include "cwg_consts.svh"
`default_nettype none
module complementary_waveform_generator
    import cwg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rise_event_in,
    input wire logic fall_event_in,
    input wire logic fault_in,
    output logic drive_out_a,
    output logic drive_out_b,
    output logic drive_out_c,
    output logic drive_out_d
);

    logic enable_r, enable_nxt;
    logic [2:0] operating_mode_select_r, operating_mode_select_nxt;
    logic [3:0] steer_r, steer_nxt;
    count_t dead_rise_r, dead_rise_nxt, dead_fall_r, dead_fall_nxt;
    count_t blank_rise_r, blank_rise_nxt, blank_fall_r, blank_fall_nxt;
    count_t phase_r, phase_nxt;
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [4:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic bvalid_r, bvalid_nxt, bad_w_r, bad_w_nxt;
    logic rvalid_r, rvalid_nxt, bad_r_r, bad_r_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    drive_state_t state_r, state_nxt;
    count_t phase_cnt_r, phase_cnt_nxt, blank_cnt_r, blank_cnt_nxt;
    logic blank_is_fall_r, blank_is_fall_nxt;
    logic pair_r, pair_nxt;
    logic shutdown_r, shutdown_nxt;
    logic rise_prev_r, fall_prev_r;
    count_t dead_p_r, dead_p_nxt, dead_c_r, dead_c_nxt;
    logic prim_r, prim_nxt, comp_r, comp_nxt;
    drive_t out_r, out_nxt;

    function automatic logic known_addr(input logic [4:0] addr);
        known_addr = (addr[1:0] == 2'h0);
    endfunction

    logic do_write, active_mode, half_mode, pp_mode, rise_edge, fall_edge, rise_ok, fall_ok, raw_on;

    assign half_mode = enable_r && (operating_mode_select_r == `MODE_HALF_BRIDGE);
    assign pp_mode = enable_r && (operating_mode_select_r == `MODE_PUSH_PULL);
    assign active_mode = half_mode || pp_mode;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign rise_edge = rise_event_in && !rise_prev_r;
    assign fall_edge = fall_event_in && !fall_prev_r;
    assign rise_ok = rise_edge && !(blank_cnt_r != 8'h00 && !blank_is_fall_r);
    assign fall_ok = fall_edge && !(blank_cnt_r != 8'h00 && blank_is_fall_r);
    assign raw_on = (state_r == ST_ON);

    always_comb begin
        enable_nxt = enable_r;
        operating_mode_select_nxt = operating_mode_select_r;
        steer_nxt = steer_r;
        dead_rise_nxt = dead_rise_r;
        dead_fall_nxt = dead_fall_r;
        blank_rise_nxt = blank_rise_r;
        blank_fall_nxt = blank_fall_r;
        phase_nxt = phase_r;
        aw_held_nxt = aw_held_r || s_axi_awvalid;
        w_held_nxt = w_held_r || s_axi_wvalid;
        awaddr_nxt = (s_axi_awvalid && !aw_held_r) ? s_axi_awaddr : awaddr_r;
        wdata_nxt = (s_axi_wvalid && !w_held_r) ? s_axi_wdata : wdata_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bad_w_nxt = bad_w_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        bad_r_nxt = bad_r_r;
        rdata_nxt = rdata_r;
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bad_w_nxt = !known_addr(awaddr_r);
            case (awaddr_r)
                `ADDR_CTRL: begin
                    enable_nxt = wdata_r[`CTRL_EN_BIT];
                    operating_mode_select_nxt = wdata_r[`CTRL_MODE_LSB +: 3];
                end
                `ADDR_STEER: steer_nxt = wdata_r[3:0];
                `ADDR_DEAD_RISE: dead_rise_nxt = wdata_r[7:0];
                `ADDR_DEAD_FALL: dead_fall_nxt = wdata_r[7:0];
                `ADDR_BLANK_RISE: blank_rise_nxt = wdata_r[7:0];
                `ADDR_BLANK_FALL: blank_fall_nxt = wdata_r[7:0];
                `ADDR_PHASE: phase_nxt = wdata_r[7:0];
                default: bad_w_nxt = 1'b1;
            endcase
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            bad_r_nxt = 1'b0;
            case (s_axi_araddr)
                `ADDR_CTRL: rdata_nxt = {25'h0000000, operating_mode_select_r, 3'h0, enable_r};
                `ADDR_STEER: rdata_nxt = {28'h0000000, steer_r};
                `ADDR_DEAD_RISE: rdata_nxt = {24'h000000, dead_rise_r};
                `ADDR_DEAD_FALL: rdata_nxt = {24'h000000, dead_fall_r};
                `ADDR_BLANK_RISE: rdata_nxt = {24'h000000, blank_rise_r};
                `ADDR_BLANK_FALL: rdata_nxt = {24'h000000, blank_fall_r};
                `ADDR_PHASE: rdata_nxt = {24'h000000, phase_r};
                `ADDR_STATUS: rdata_nxt = {24'h000000, out_r, 1'b0, pair_r, shutdown_r, raw_on};
                default: begin
                    rdata_nxt = 32'h00000000;
                    bad_r_nxt = 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        state_nxt = state_r;
        phase_cnt_nxt = phase_cnt_r;
        blank_cnt_nxt = (blank_cnt_r != 8'h00) ? blank_cnt_r - 8'h01 : 8'h00;
        blank_is_fall_nxt = blank_is_fall_r;
        // Outside push-pull the pair is parked so that the first push-pull period drives A and C.
        pair_nxt = pp_mode ? pair_r : 1'b1;
        shutdown_nxt = shutdown_r;
        // Fault latches shutdown; a control write with the clear bit releases it, but an active fault wins.
        if (do_write && awaddr_r == `ADDR_CTRL && wdata_r[`CTRL_CLR_BIT]) begin
            shutdown_nxt = 1'b0;
        end
        if (fault_in) begin
            shutdown_nxt = 1'b1;
        end
        if (!active_mode || shutdown_nxt) begin
            state_nxt = ST_OFF;
        end else begin
            case (state_r)
                ST_OFF: begin
                    if (rise_ok) begin
                        pair_nxt = pp_mode ? !pair_r : 1'b1;
                        if (phase_r != 8'h00) begin
                            state_nxt = ST_PHASE;
                            phase_cnt_nxt = phase_r - 8'h01;
                        end else begin
                            state_nxt = ST_ON;
                            blank_cnt_nxt = blank_rise_r;
                            blank_is_fall_nxt = 1'b1;
                        end
                    end
                end
                ST_PHASE: begin
                    if (fall_ok) begin
                        state_nxt = ST_OFF;
                    end else if (phase_cnt_r == 8'h00) begin
                        state_nxt = ST_ON;
                        blank_cnt_nxt = blank_rise_r;
                        blank_is_fall_nxt = 1'b1;
                    end else begin
                        phase_cnt_nxt = phase_cnt_r - 8'h01;
                    end
                end
                ST_ON: begin
                    if (fall_ok) begin
                        state_nxt = ST_OFF;
                        blank_cnt_nxt = blank_fall_r;
                        blank_is_fall_nxt = 1'b0;
                    end
                end
                default: state_nxt = ST_OFF;
            endcase
        end
    end

    always_comb begin
        prim_nxt = prim_r;
        comp_nxt = comp_r;
        dead_p_nxt = 8'h00;
        dead_c_nxt = 8'h00;
        // Each output turns on only after the other has been off for its dead count.
        if (!half_mode || shutdown_r) begin
            prim_nxt = 1'b0;
            comp_nxt = 1'b0;
        end else if (raw_on) begin
            comp_nxt = 1'b0;
            if (dead_p_r >= dead_rise_r) begin
                prim_nxt = 1'b1;
            end else begin
                dead_p_nxt = dead_p_r + 8'h01;
            end
        end else begin
            prim_nxt = 1'b0;
            if (dead_c_r >= dead_fall_r) begin
                comp_nxt = 1'b1;
            end else begin
                dead_c_nxt = dead_c_r + 8'h01;
            end
        end
        out_nxt = '0;
        if (half_mode && !shutdown_r) begin
            out_nxt.a = prim_r && steer_r[`STEER_A_BIT];
            out_nxt.c = prim_r && steer_r[`STEER_C_BIT];
            out_nxt.b = comp_r && steer_r[`STEER_B_BIT];
            out_nxt.d = comp_r && steer_r[`STEER_D_BIT];
        end else if (pp_mode && !shutdown_r && raw_on) begin
            out_nxt.a = !pair_r;
            out_nxt.c = !pair_r;
            out_nxt.b = pair_r;
            out_nxt.d = pair_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= 1'b0;
            operating_mode_select_r <= 3'h0;
            steer_r <= `STEER_RESET;
            dead_rise_r <= `COUNT_RESET;
            dead_fall_r <= `COUNT_RESET;
            blank_rise_r <= `COUNT_RESET;
            blank_fall_r <= `COUNT_RESET;
            phase_r <= `COUNT_RESET;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 5'h00;
            wdata_r <= 32'h00000000;
            bvalid_r <= 1'b0;
            bad_w_r <= 1'b0;
            rvalid_r <= 1'b0;
            bad_r_r <= 1'b0;
            rdata_r <= 32'h00000000;
            state_r <= ST_OFF;
            phase_cnt_r <= 8'h00;
            blank_cnt_r <= 8'h00;
            blank_is_fall_r <= 1'b0;
            pair_r <= 1'b1;
            shutdown_r <= 1'b0;
            rise_prev_r <= 1'b0;
            // The falling source idles high, so no false edge follows reset.
            fall_prev_r <= 1'b1;
            dead_p_r <= 8'h00;
            dead_c_r <= 8'h00;
            prim_r <= 1'b0;
            comp_r <= 1'b0;
            out_r <= '0;
        end else begin
            enable_r <= enable_nxt;
            operating_mode_select_r <= operating_mode_select_nxt;
            steer_r <= steer_nxt;
            dead_rise_r <= dead_rise_nxt;
            dead_fall_r <= dead_fall_nxt;
            blank_rise_r <= blank_rise_nxt;
            blank_fall_r <= blank_fall_nxt;
            phase_r <= phase_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            bvalid_r <= bvalid_nxt;
            bad_w_r <= bad_w_nxt;
            rvalid_r <= rvalid_nxt;
            bad_r_r <= bad_r_nxt;
            rdata_r <= rdata_nxt;
            state_r <= state_nxt;
            phase_cnt_r <= phase_cnt_nxt;
            blank_cnt_r <= blank_cnt_nxt;
            blank_is_fall_r <= blank_is_fall_nxt;
            pair_r <= pair_nxt;
            shutdown_r <= shutdown_nxt;
            rise_prev_r <= rise_event_in;
            fall_prev_r <= fall_event_in;
            dead_p_r <= dead_p_nxt;
            dead_c_r <= dead_c_nxt;
            prim_r <= prim_nxt;
            comp_r <= comp_nxt;
            out_r <= out_nxt;
        end
    end

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bad_w_r ? 2'h2 : 2'h0;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = bad_r_r ? 2'h2 : 2'h0;
    assign drive_out_a = out_r.a;
    assign drive_out_b = out_r.b;
    assign drive_out_c = out_r.c;
    assign drive_out_d = out_r.d;

endmodule
`default_nettype wire

// file: cwg_properties.sv
`include "cwg_consts.svh"
`default_nettype none
module cwg_properties import cwg_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fault_in,
    input wire logic drive_out_a,
    input wire logic drive_out_b,
    input wire logic drive_out_c,
    input wire logic drive_out_d
);
    logic ctl_wr, pp_r, pp_nxt, on_r, on_nxt, last_r, last_nxt, pa_r, pb_r, idle;
    always_comb begin
        ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 5'h00;
        pp_nxt = ctl_wr ? s_axi_wdata[0] && s_axi_wdata[6:4] == `MODE_PUSH_PULL : pp_r;
        on_nxt = ctl_wr ? s_axi_wdata[0] && s_axi_wdata[6:5] == 2'h2 : on_r;
        last_nxt = !pp_r || (drive_out_b && !pb_r) || (last_r && !(drive_out_a && !pa_r));
        idle = !(drive_out_a || drive_out_b || drive_out_c || drive_out_d);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {pp_r, on_r, last_r, pa_r, pb_r} <= 5'h00;
        end else begin
            {pp_r, on_r, last_r, pa_r, pb_r} <= {pp_nxt, on_nxt, last_nxt, drive_out_a, drive_out_b};
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_fault; fault_in |-> ##[1:3] idle; endproperty
    a_fault: assert property (p_fault) else $error("drive kept during fault");
    property p_copy; pp_r && $past(pp_r, 3) |-> drive_out_c == drive_out_a && drive_out_d == drive_out_b; endproperty
    a_copy: assert property (p_copy) else $error("pair copy broken");
    property p_one; pp_r && $past(pp_r, 3) |-> !(drive_out_a && drive_out_b); endproperty
    a_one: assert property (p_one) else $error("both pairs driven");
    property p_alt; pp_r && ($rose(drive_out_a) || $rose(drive_out_b)) |-> drive_out_a == last_r; endproperty
    a_alt: assert property (p_alt) else $error("pair did not alternate");
    property p_off; !on_r && !$past(on_r, 3) |-> idle; endproperty
    a_off: assert property (p_off) else $error("drive in idle mode");
    c_alt: cover property (pp_r && $rose(drive_out_b));
    c_fault: cover property (fault_in && !idle);
    c_rhold: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
`default_nettype wire

// file: pwm_event_source.sv
`default_nettype none
module pwm_event_source #(parameter int PERIOD = 10, parameter int HIGH = 4) (
    input wire logic aclk,
    input wire logic run,
    output logic rise_ev,
    output logic fall_ev
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    initial begin
        cnt = 0;
        rise_ev = 1'b0;
        fall_ev = 1'b1;
    end
    always @(posedge aclk) begin
        cnt <= (cnt == PERIOD - 1 || !run) ? 0 : cnt + 1;
        rise_ev <= run && cnt < HIGH;
        fall_ev <= !(run && cnt < HIGH);
    end
endmodule
`default_nettype wire

// file: complementary_waveform_generator_bench.sv
`include "cwg_consts.svh"
`default_nettype none
module complementary_waveform_generator_bench import cwg_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rise_event_in, fall_event_in, fault_in, run;
    logic drive_out_a, drive_out_b, drive_out_c, drive_out_d;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, drv;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares, n_checks;
    assign drv = {drive_out_a, drive_out_b, drive_out_c, drive_out_d};
    complementary_waveform_generator u_complementary_waveform_generator (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rise_event_in, .fall_event_in, .fault_in,
        .drive_out_a, .drive_out_b, .drive_out_c, .drive_out_d
    );
    pwm_event_source u_pwm_event_source (.aclk, .run, .rise_ev(rise_event_in), .fall_ev(fall_event_in));
    always #50 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] dt, input logic [1:0] er);
        logic aw, w;
        {aw, w} = 2'h0;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw || s_axi_awready === 1'b1;
            w = w || s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [4:0] ad, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] ad, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(ad, d, r);
        chk(r, 2'h0);
        chk(d, e);
    endtask
    task automatic acc(input logic [3:0] e);
        logic [3:0] s;
        s = 4'h0;
        repeat (12) @(posedge aclk);
        repeat (40) begin
            @(posedge aclk);
            s = s | drv;
        end
        chk(s, e);
    endtask
    task automatic pw(input int k, input logic [31:0] e);
        logic [31:0] n;
        n = 32'h0;
        while (drv[k] !== 1'b0) @(posedge aclk);
        while (drv[k] !== 1'b1) @(posedge aclk);
        while (drv[k] === 1'b1) begin
            n++;
            @(posedge aclk);
        end
        chk(n, e);
    endtask
    task automatic dl(output logic [31:0] n);
        n = 32'h0;
        @(posedge rise_event_in);
        while ((drv[3] | drv[2]) !== 1'b1) begin
            n++;
            @(posedge aclk);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        end_sim;
    end
    initial begin
        logic [31:0] d, n0, n3;
        logic [1:0] r;
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fault_in, run} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
        s_axi_wstrb = 4'hF;
        miscompares = 0;
        n_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`ADDR_CTRL, `CTRL_RESET);
        rdc(`ADDR_STEER, 32'h0000000F);
        for (int i = 8; i <= 24; i += 4) begin
            rdc(5'(i), 32'h00000000);
        end
        wr(5'h02, 32'h00000041, 2'h2);
        rd(5'h02, d, r);
        chk(r, 2'h2);
        rdc(`ADDR_CTRL, 32'h00000000);
        wr(`ADDR_DEAD_RISE, 32'h000001A5, 2'h0);
        rdc(`ADDR_DEAD_RISE, 32'h000000A5);
        wr(`ADDR_DEAD_RISE, 32'h00000000, 2'h0);
        run <= 1'b1;
        wr(`ADDR_CTRL, 32'h00000041, 2'h0);
        acc(4'hF);
        pw(3, 32'h4);
        pw(2, 32'h6);
        pw(1, 32'h4);
        pw(0, 32'h6);
        wr(`ADDR_DEAD_RISE, 32'h00000002, 2'h0);
        pw(3, 32'h2);
        wr(`ADDR_DEAD_RISE, 32'h00000000, 2'h0);
        wr(`ADDR_STEER, 32'h00000003, 2'h0);
        acc(4'hC);
        wr(`ADDR_STEER, 32'h0000000F, 2'h0);
        fault_in <= 1'b1;
        repeat (3) @(posedge aclk);
        fault_in <= 1'b0;
        acc(4'h0);
        rd(`ADDR_STATUS, d, r);
        chk(d & 32'h00000002, 32'h00000002);
        wr(`ADDR_CTRL, 32'h00000141, 2'h0);
        acc(4'hF);
        wr(`ADDR_CTRL, 32'h00000000, 2'h0);
        wr(`ADDR_CTRL, 32'h00000031, 2'h0);
        acc(4'h0);
        wr(`ADDR_CTRL, 32'h00000000, 2'h0);
        wr(`ADDR_CTRL, 32'h00000051, 2'h0);
        acc(4'hF);
        pw(3, 32'h4);
        pw(0, 32'h4);
        dl(n0);
        wr(`ADDR_PHASE, 32'h00000003, 2'h0);
        dl(n3);
        chk(n3, n0 + 32'h3);
        wr(`ADDR_PHASE, 32'h00000000, 2'h0);
        wr(`ADDR_BLANK_RISE, 32'h00000008, 2'h0);
        pw(3, 32'hE);
        end_sim;
    end
endmodule
bind complementary_waveform_generator cwg_properties u_cwg_properties (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .fault_in, .drive_out_a, .drive_out_b, .drive_out_c, .drive_out_d
);
`default_nettype wire
